// [common/fskbs_pkg.sv]
// Package with register map, field layout and constants of the FSK data path block
package fskbs_pkg;

  // ********************************************************************
  // Register offsets (byte addresses are four times the index)
  // ********************************************************************
  localparam logic [11:0] IDX_MODE_POWER = 12'h000;
  localparam logic [11:0] IDX_MOD_RSSI = 12'h001;
  localparam logic [11:0] IDX_PUMP_BYPASS = 12'h002;
  localparam logic [11:0] IDX_MOD_FILT_CUR = 12'h004;
  localparam logic [11:0] IDX_MOD_ATTEN = 12'h005;
  localparam logic [11:0] IDX_CLK_SCALE = 12'h006;
  localparam logic [11:0] IDX_BITRATE_REFDIV = 12'h007;
  localparam logic [11:0] IDX_STATUS = 12'h008;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int MP_SYNC_EN = 3;
  localparam int MP_MODE_LO = 1;
  localparam int MP_PWR_LO = 4;
  localparam int MR_METH_LO = 6;
  localparam int PB_PA_BYPASS = 4;
  localparam int CS_BS_LO = 1;
  localparam int CS_MOD_LO = 4;
  localparam int BR_REFK_LO = 0;

  // ********************************************************************
  // Reset values and reserved bit masks
  // ********************************************************************
  localparam logic [7:0] RST_MOD_ATTEN = 8'h10;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MASK_MOD_RSSI = 8'hcf;
  localparam logic [7:0] MASK_PUMP = 8'hdf;
  localparam logic [7:0] MASK_ATTEN = 8'h0f;
  localparam logic [7:0] MASK_CLK = 8'h7f;

  // ********************************************************************
  // Timing constants
  // ********************************************************************
  localparam logic [4:0] OVERSAMPLE = 5'h10;
  localparam logic [3:0] SAMPLE_PHASE = 4'h8;
  localparam logic [2:0] SCALE_TOP = 3'h7;
  localparam logic [4:0] LOCK_SYMBOLS = 5'h16;
  localparam logic [1:0] EDGE_PERIODS = 2'h3;
  localparam logic [5:0] REFK_MIN = 6'h01;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    FSKBS_SLEEP,
    FSKBS_RX,
    FSKBS_TX,
    FSKBS_STBY
  } fskbs_mode_t;

  typedef enum logic [1:0] {
    FSKBS_METH_MODULATOR = 2'h0,
    FSKBS_METH_RSV1 = 2'h1,
    FSKBS_METH_TWO_DIV = 2'h2,
    FSKBS_METH_RSV3 = 2'h3
  } fskbs_method_t;

  typedef struct packed {
    logic pa_enable;
    logic pa_bypass;
    logic [2:0] pa_level;
  } fskbs_pa_t;

  typedef struct packed {
    logic use_set_one;
    logic mod_active;
    logic [1:0] mod_dir;
    logic [2:0] mod_weight;
  } fskbs_synth_t;

endpackage

// [rtl/fskbs_core.sv]
// FSK data path control: registers, clock dividers, bit sync, PA and modulation control
`timescale 1ns/1ns
// Function
// - Bit synchronizer runs only in receive mode with sync enable set
// - In sync receive mode a recovered clock is driven on the clock pin
// - Received symbol changes on the data pin at recovered clock rising edge
// - Bitsync clock is xtal over refdiv times two to (7 minus scale)
// - Reference divider is six bits 1..63; bitsync scale is three bits
// - One reference divider feeds bitsync, modulator and bit rate clocks
// - Bit synchronizer locks within 22 symbols from packet start
// - Power level 0 turns amplifier off, 1 is maximum, seven steps
// - Bypass bit bypasses amplifier while power level still applies
// - Method 00 selects modulator, 10 selects two divider sets
// - Two divider mode uses set zero for data 0, set one for 1
// - Data pin is input in transmit and output in receive
// - Modulator mode: tristated pin keeps LO, driven level shifts carrier
// - Two divider mode: tristated pin selects divider set zero
// - Each modulator edge spans 4 modulator clock periods, unequal currents
module fskbs_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Crystal clock enable and receive demodulator
  input wire logic xco_tick,
  input wire logic demod_data,
  // Data pin and recovered clock pin
  input wire logic data_io_pin_i,
  input wire logic data_io_pin_z,
  output logic data_io_pin_o,
  output logic data_io_pin_oe,
  output logic recovered_clock_pin,
  // Analog control
  input wire logic pll_locked,
  output fskbs_pkg::fskbs_pa_t pa_ctrl,
  output fskbs_pkg::fskbs_synth_t synth_ctrl,
  output logic bitsync_locked,
  output logic mod_clk_en,
  output logic bitrate_clk_en
);

  // ********************************************************************
  // Register file
  // ********************************************************************
  logic [7:0] mode_power_control_reg;
  logic [7:0] modulation_rssi_filter_control_reg;
  logic [7:0] pump_bypass_output_select_reg;
  logic [7:0] modulator_filter_current_reg;
  logic [7:0] modulator_attenuation_reg;
  logic [7:0] clock_scale_settings_reg;
  logic [7:0] bitrate_scale_reference_divider_reg;

  wire [11:0] word_idx = {2'h0, paddr[11:2]};
  wire wr_go = psel && penable && pwrite;
  wire hit_mp = (word_idx == fskbs_pkg::IDX_MODE_POWER);
  wire hit_mr = (word_idx == fskbs_pkg::IDX_MOD_RSSI);
  wire hit_pb = (word_idx == fskbs_pkg::IDX_PUMP_BYPASS);
  wire hit_mf = (word_idx == fskbs_pkg::IDX_MOD_FILT_CUR);
  wire hit_ma = (word_idx == fskbs_pkg::IDX_MOD_ATTEN);
  wire hit_cs = (word_idx == fskbs_pkg::IDX_CLK_SCALE);
  wire hit_br = (word_idx == fskbs_pkg::IDX_BITRATE_REFDIV);
  wire hit_st = (word_idx == fskbs_pkg::IDX_STATUS);
  wire hit_any = hit_mp | hit_mr | hit_pb | hit_mf | hit_ma | hit_cs | hit_br | hit_st;
  wire [7:0] wbyte = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_power_control_reg <= fskbs_pkg::RST_ZERO;
      modulation_rssi_filter_control_reg <= fskbs_pkg::RST_ZERO;
      pump_bypass_output_select_reg <= fskbs_pkg::RST_ZERO;
      modulator_filter_current_reg <= fskbs_pkg::RST_ZERO;
      modulator_attenuation_reg <= fskbs_pkg::RST_MOD_ATTEN;
      clock_scale_settings_reg <= fskbs_pkg::RST_ZERO;
      bitrate_scale_reference_divider_reg <= fskbs_pkg::RST_ZERO;
    end else if (wr_go) begin
      if (hit_mp) mode_power_control_reg <= wbyte;
      if (hit_mr) modulation_rssi_filter_control_reg <= wbyte & fskbs_pkg::MASK_MOD_RSSI;
      if (hit_pb) pump_bypass_output_select_reg <= wbyte & fskbs_pkg::MASK_PUMP;
      if (hit_mf) modulator_filter_current_reg <= wbyte;
      if (hit_ma) begin
        modulator_attenuation_reg <= (wbyte & fskbs_pkg::MASK_ATTEN) | fskbs_pkg::RST_MOD_ATTEN;
      end
      if (hit_cs) clock_scale_settings_reg <= wbyte & fskbs_pkg::MASK_CLK;
      if (hit_br) bitrate_scale_reference_divider_reg <= wbyte;
    end
  end

  // Status byte: lock, pin drive, active divider set, PLL lock
  wire [7:0] status_byte = {4'h0, pll_locked, synth_ctrl.use_set_one, data_io_pin_oe,
    bitsync_locked};
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_mp) rd_byte = mode_power_control_reg;
    if (hit_mr) rd_byte = modulation_rssi_filter_control_reg;
    if (hit_pb) rd_byte = pump_bypass_output_select_reg;
    if (hit_mf) rd_byte = modulator_filter_current_reg;
    if (hit_ma) rd_byte = modulator_attenuation_reg;
    if (hit_cs) rd_byte = clock_scale_settings_reg;
    if (hit_br) rd_byte = bitrate_scale_reference_divider_reg;
    if (hit_st) rd_byte = status_byte;
  end
  assign prdata = {24'h000000, rd_byte};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ********************************************************************
  // Field decode
  // ********************************************************************
  fskbs_pkg::fskbs_mode_t op_mode;
  assign op_mode = fskbs_pkg::fskbs_mode_t'(mode_power_control_reg[fskbs_pkg::MP_MODE_LO +: 2]);
  wire sync_en = mode_power_control_reg[fskbs_pkg::MP_SYNC_EN];
  wire [2:0] pwr_level = mode_power_control_reg[fskbs_pkg::MP_PWR_LO +: 3];
  wire [1:0] meth_code = modulation_rssi_filter_control_reg[fskbs_pkg::MR_METH_LO +: 2];
  wire [2:0] bs_scale = clock_scale_settings_reg[fskbs_pkg::CS_BS_LO +: 3];
  wire [2:0] mod_scale = clock_scale_settings_reg[fskbs_pkg::CS_MOD_LO +: 3];
  wire [2:0] br_scale = {clock_scale_settings_reg[0], bitrate_scale_reference_divider_reg[7:6]};
  wire [5:0] ref_k = bitrate_scale_reference_divider_reg[fskbs_pkg::BR_REFK_LO +: 6];
  wire rx_mode = (op_mode == fskbs_pkg::FSKBS_RX);
  wire tx_mode = (op_mode == fskbs_pkg::FSKBS_TX);
  wire sync_run = rx_mode && sync_en;
  wire two_div = (meth_code == fskbs_pkg::FSKBS_METH_TWO_DIV);

  // ********************************************************************
  // Shared reference divider and power of two scalers
  // ********************************************************************
  function automatic logic scale_tick(input logic [6:0] cnt, input logic [2:0] sc);
    logic [6:0] mask;
    mask = 7'h7f >> sc;
    scale_tick = ((cnt & mask) == mask);
  endfunction

  logic [5:0] ref_cnt_reg;
  logic [6:0] pre_cnt_reg;
  wire [5:0] ref_k_eff = (ref_k < fskbs_pkg::REFK_MIN) ? fskbs_pkg::REFK_MIN : ref_k;
  wire ref_tick = xco_tick && (ref_cnt_reg >= ref_k_eff - fskbs_pkg::REFK_MIN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg <= 6'h00;
      pre_cnt_reg <= 7'h00;
    end else if (xco_tick) begin
      ref_cnt_reg <= ref_tick ? 6'h00 : ref_cnt_reg + 6'h01;
      if (ref_tick) pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  // Each rate is ref tick divided by 2^(7-scale)
  wire bs_tick = ref_tick && scale_tick(pre_cnt_reg, bs_scale);
  assign mod_clk_en = ref_tick && scale_tick(pre_cnt_reg, mod_scale);
  assign bitrate_clk_en = ref_tick && scale_tick(pre_cnt_reg, br_scale);

  // ********************************************************************
  // Bit synchronizer
  // ********************************************************************
  logic [3:0] phase_reg;
  logic prev_rx_reg;
  logic rec_clk_reg;
  logic rx_bit_reg;
  logic [4:0] sym_cnt_reg;
  logic locked_reg;
  wire rx_edge = bs_tick && (demod_data != prev_rx_reg);
  wire centre = bs_tick && (phase_reg == fskbs_pkg::SAMPLE_PHASE);
  wire early = phase_reg < fskbs_pkg::SAMPLE_PHASE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 4'h0;
      prev_rx_reg <= 1'b0;
      rec_clk_reg <= 1'b0;
      rx_bit_reg <= 1'b0;
      sym_cnt_reg <= 5'h00;
      locked_reg <= 1'b0;
    end else if (!sync_run) begin
      phase_reg <= 4'h0;
      rec_clk_reg <= 1'b0;
      sym_cnt_reg <= 5'h00;
      locked_reg <= 1'b0;
    end else if (bs_tick) begin
      prev_rx_reg <= demod_data;
      // Nudge phase towards edge at zero, one step per edge
      if (rx_edge && phase_reg != 4'h0) begin
        phase_reg <= early ? phase_reg : phase_reg + 4'h2;
      end else begin
        phase_reg <= phase_reg + 4'h1;
      end
      if (centre) begin
        rec_clk_reg <= 1'b1;
        rx_bit_reg <= demod_data;
        if (sym_cnt_reg != fskbs_pkg::LOCK_SYMBOLS) sym_cnt_reg <= sym_cnt_reg + 5'h01;
        if (sym_cnt_reg == fskbs_pkg::LOCK_SYMBOLS - 5'h01) locked_reg <= 1'b1;
      end else if (early) begin
        rec_clk_reg <= 1'b0;
      end
    end
  end
  assign recovered_clock_pin = rec_clk_reg;
  assign bitsync_locked = locked_reg;

  // ********************************************************************
  // Data pin direction
  // ********************************************************************
  assign data_io_pin_oe = rx_mode;
  assign data_io_pin_o = sync_run ? rx_bit_reg : (rx_mode && demod_data);

  // ********************************************************************
  // Power amplifier
  // ********************************************************************
  wire pa_on = tx_mode && (pwr_level != 3'h0);
  wire pa_byp = pump_bypass_output_select_reg[fskbs_pkg::PB_PA_BYPASS];
  wire [2:0] pa_lvl = pwr_level;
  assign pa_ctrl = {pa_on, pa_byp, pa_lvl};

  // ********************************************************************
  // Modulation control and edge shaping
  // ********************************************************************
  wire tx_drive = tx_mode && !data_io_pin_z;
  wire set_one = two_div && tx_drive && data_io_pin_i;

  logic target_reg;
  logic [1:0] edge_cnt_reg;
  logic ramp_reg;
  wire mod_path = tx_drive && !two_div;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_reg <= 1'b0;
      edge_cnt_reg <= 2'h0;
      ramp_reg <= 1'b0;
    end else if (mod_clk_en) begin
      if (ramp_reg) begin
        if (edge_cnt_reg == fskbs_pkg::EDGE_PERIODS) ramp_reg <= 1'b0;
        edge_cnt_reg <= edge_cnt_reg + 2'h1;
      end else if (mod_path && data_io_pin_i != target_reg) begin
        target_reg <= data_io_pin_i;
        ramp_reg <= 1'b1;
        edge_cnt_reg <= 2'h0;
      end
    end
  end
  wire [1:0] dir_code = !mod_path ? 2'h0 : (target_reg ? 2'h1 : 2'h2);
  // Weights 1,3,3,1 soften both ends of every edge
  wire [2:0] weight = !ramp_reg ? 3'h0 :
    ((edge_cnt_reg == 2'h0 || edge_cnt_reg == fskbs_pkg::EDGE_PERIODS) ? 3'h1 : 3'h3);
  assign synth_ctrl = {set_one, mod_path, dir_code, weight};

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_bs_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !sync_run |=> !recovered_clock_pin && !bitsync_locked) else $error("bitsync ran while off");
  chk_data_update: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(rx_bit_reg) |-> $rose(recovered_clock_pin)) else $error("data moved off edge");
  chk_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
    data_io_pin_oe == rx_mode) else $error("pin direction wrong");
  chk_pa_off: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_level == 3'h0 |-> !pa_ctrl.pa_enable) else $error("amplifier on at level zero");
  chk_set_zero: assert property (@(posedge pclk) disable iff (!presetn)
    data_io_pin_z |-> !synth_ctrl.use_set_one) else $error("tristate chose set one");
  chk_set_one: assert property (@(posedge pclk) disable iff (!presetn)
    two_div && tx_mode && !data_io_pin_z && data_io_pin_i |-> synth_ctrl.use_set_one)
    else $error("data one missed set one");
  chk_rsv_meth: assert property (@(posedge pclk) disable iff (!presetn)
    meth_code[0] |-> !synth_ctrl.use_set_one) else $error("reserved code not modulator");
  chk_lock_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(bitsync_locked) |-> sym_cnt_reg == fskbs_pkg::LOCK_SYMBOLS)
    else $error("lock at wrong count");
  chk_edge_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ramp_reg) |-> $past(edge_cnt_reg) == fskbs_pkg::EDGE_PERIODS && $past(mod_clk_en))
    else $error("edge length wrong");
  chk_ramp_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ramp_reg) |-> edge_cnt_reg == 2'h0) else $error("edge began mid count");
  chk_clk_phase: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(recovered_clock_pin) |-> $past(phase_reg) == fskbs_pkg::SAMPLE_PHASE)
    else $error("clock rose off centre");
  chk_tri_lo: assert property (@(posedge pclk) disable iff (!presetn)
    data_io_pin_z |-> synth_ctrl.mod_dir == 2'h0) else $error("tristate shifted carrier");

  cov_lock: cover property (@(posedge pclk) disable iff (!presetn) $rose(bitsync_locked));
  cov_two_div: cover property (@(posedge pclk) disable iff (!presetn) $rose(synth_ctrl.use_set_one));
  cov_ramp: cover property (@(posedge pclk) disable iff (!presetn) $fell(ramp_reg));
  cov_bypass: cover property (@(posedge pclk) disable iff (!presetn) $rose(pa_ctrl.pa_bypass));

endmodule

// [test/fskbs_host.sv]
// Host controller model on the far side of the data pin and recovered clock pin
`timescale 1ns/1ns
module fskbs_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic tx_go,
  input wire logic tx_bit,
  // Device status
  input wire logic pll_locked,
  input wire logic pa_enable,
  // Pins
  input wire logic data_io_pin_o,
  input wire logic data_io_pin_oe,
  input wire logic recovered_clock_pin,
  output logic data_io_pin_i,
  output logic data_io_pin_z,
  output logic rx_bit
);
  // ********************************************************************
  // Transmit drive and receive capture
  // ********************************************************************
  // Pin stays released until lock and amplifier on; released level wanders
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_io_pin_z <= 1'b1;
      data_io_pin_i <= 1'b0;
    end else if (tx_go && pll_locked && pa_enable && !data_io_pin_oe) begin
      data_io_pin_z <= 1'b0;
      data_io_pin_i <= tx_bit;
    end else begin
      data_io_pin_z <= 1'b1;
      data_io_pin_i <= ~data_io_pin_i;
    end
  end

  // Received symbol taken on the falling edge of the recovered clock
  always @(negedge recovered_clock_pin) begin
    if (data_io_pin_oe) begin
      rx_bit <= data_io_pin_o;
    end
  end
endmodule

// [test/fskbs_core_bench.sv]
// Self-checking bench of the FSK data path control block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fskbs_core_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, demod_data = 1'b0, pll_locked = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pin_i, pin_z, pin_o, pin_oe, rclk, locked, mclk, bclk, rx_bit, rc_q, d_q;
  logic tx_go = 1'b0, tx_bit = 1'b0, rmode = 1'b1, dbit = 1'b0;
  fskbs_pkg::fskbs_pa_t pa;
  fskbs_pkg::fskbs_synth_t sy;
  logic [32:0] exp_q[$];
  logic [32:0] q;
  logic [7:0] shadow[0:8];
  logic [31:0] seed = 32'h0000d8ab;
  logic flag_a = 1'b0;
  logic [19:0] code;
  int err_total = 0, checked = 0, bit_per = 48, cyc = 0, n, k, w;

  always #20 pclk = ~pclk;

  fskbs_core fskbs_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xco_tick(1'b1), .demod_data(demod_data), .data_io_pin_i(pin_i),
    .data_io_pin_z(pin_z), .data_io_pin_o(pin_o), .data_io_pin_oe(pin_oe),
    .recovered_clock_pin(rclk), .pll_locked(pll_locked), .pa_ctrl(pa), .synth_ctrl(sy),
    .bitsync_locked(locked), .mod_clk_en(mclk), .bitrate_clk_en(bclk));

  fskbs_host fskbs_host_i (.pclk(pclk), .presetn(presetn), .tx_go(tx_go), .tx_bit(tx_bit),
    .pll_locked(pll_locked), .pa_enable(pa.pa_enable), .data_io_pin_o(pin_o),
    .data_io_pin_oe(pin_oe), .recovered_clock_pin(rclk), .data_io_pin_i(pin_i),
    .data_io_pin_z(pin_z), .rx_bit(rx_bit));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] msk(input int i);
    case (i)
      1: return fskbs_pkg::MASK_MOD_RSSI;
      2: return fskbs_pkg::MASK_PUMP;
      5: return fskbs_pkg::MASK_ATTEN;
      6: return fskbs_pkg::MASK_CLK;
      default: return 8'hff;
    endcase
  endfunction

  function automatic logic [1:0] manch(input logic d);
    return d ? 2'b01 : 2'b10;
  endfunction

  // 3B4B word; the flag alternates word A and B over 000 and 111
  function automatic logic [3:0] enc34(input logic [2:0] d);
    logic [3:0] r;
    case (d)
      3'h1: r = 4'hc;
      3'h2: r = 4'h3;
      3'h3: r = 4'ha;
      3'h4: r = 4'h5;
      3'h5: r = 4'h9;
      3'h6: r = 4'h6;
      3'h0: r = flag_a ? 4'h4 : 4'hb;
      default: r = flag_a ? 4'h2 : 4'hd;
    endcase
    if (d == 3'h0 || d == 3'h7) flag_a = !flag_a;
    return r;
  endfunction

  function automatic logic [19:0] enc_str(input logic [14:0] d);
    logic [19:0] r;
    flag_a = 1'b0;
    r = 20'h0;
    for (int g = 4; g >= 0; g--) r = {r[15:0], enc34(d[g*3 +: 3])};
    return r;
  endfunction

  function automatic logic sig(input int s);
    return (s == 0) ? mclk : (s == 1) ? bclk : rclk;
  endfunction

  task automatic finish_test();
    $display("Counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input int idx, input logic [7:0] d);
    logic e;
    logic [31:0] r;
    e = !(idx inside {0, 1, 2, 4, 5, 6, 7, 8});
    exp_q.push_back({e, (e || wr) ? 32'h0 : {24'h0, shadow[idx]}});
    if (wr && !e) shadow[idx] = (d & msk(idx)) | ((idx == 5) ? fskbs_pkg::RST_MOD_ATTEN : 8'h00);
    r = xs();
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 12'(idx * 4);
    pwdata <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sends elements MSB first on the pin, then checks the carrier shift
  task automatic send(input logic [19:0] w, input int len);
    for (int j = len - 1; j >= 0; j--) begin
      @(posedge pclk);
      tx_bit <= w[j];
      repeat (72) @(negedge pclk);
      `CHK(sy.mod_dir, w[j] ? 2'h1 : 2'h2)
    end
  endtask

  task automatic per(input int s, output int n);
    logic p, v;
    n = 0;
    for (int j = 0; j < 2; j++) begin
      do begin p = sig(s); @(negedge pclk); v = sig(s); n += j; end while (!(v && !p));
    end
  endtask

  // ********************************************************************
  // Receive stream and result watcher
  // ********************************************************************
  initial forever begin
    repeat (bit_per) @(posedge pclk);
    demod_data <= rmode ? 1'(xs()) : dbit;
  end

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      q = exp_q.pop_front();
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, q)
    end
    if (rclk && rc_q && pin_oe && pin_o !== d_q) `CHK(pin_o, d_q)
    rc_q <= rclk;
    d_q <= pin_o;
    cyc <= cyc + 1;
    if (cyc > 40000) begin
      err_total++;
      finish_test();
    end
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    for (int i = 0; i < 9; i++) shadow[i] = 8'h00;
    shadow[5] = fskbs_pkg::RST_MOD_ATTEN;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) apb(1'b0, i, 8'h00);
    apb(1'b1, 3, 8'h5a);
    for (int i = 1; i < 6; i++) begin
      apb(1'b1, i, 8'(xs()));
      apb(1'b0, i, 8'h00);
    end
    $display("Test registers done");
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 2, {3'h0, i[3], 4'h0});
      apb(1'b1, 0, {1'b0, i[2:0], 4'h4});
      @(negedge pclk);
      `CHK(pa, {i[2:0] != 3'h0, i[3], i[2:0]})
    end
    $display("Test amplifier done");
    apb(1'b1, 6, 8'h5f);
    apb(1'b1, 7, 8'h83);
    per(0, n);
    `CHK(n, 12)
    per(1, n);
    `CHK(n, 6)
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 0, m ? 8'h0c : 8'h02);
      k = 0;
      repeat (200) begin @(negedge pclk); k += rclk; end
      `CHK(k, 0)
      `CHK(locked, 1'b0)
    end
    apb(1'b1, 0, 8'h0a);
    k = 0;
    while (locked !== 1'b1 && k < 24 * 48) begin @(negedge pclk); k++; end
    `CHK(locked, 1'b1)
    `CHK(pin_oe, 1'b1)
    shadow[8] = 8'h03;
    apb(1'b0, 8, 8'h00);
    rmode = 1'b0;
    per(2, n);
    `CHK(n, 48)
    for (int b = 1; b >= 0; b--) begin
      rmode = 1'b0;
      dbit = b[0];
      repeat (480) @(posedge pclk);
      `CHK(rx_bit, b[0])
    end
    $display("Test bit sync done");
    pll_locked <= 1'b1;
    apb(1'b1, 0, 8'h14);
    @(negedge pclk);
    `CHK(pin_oe, 1'b0)
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 1, {m[1:0], 6'h00});
      for (int s = 0; s < 3; s++) begin
        @(posedge pclk);
        tx_go <= s != 0;
        tx_bit <= s == 2;
        repeat (4) @(negedge pclk);
        `CHK(sy.use_set_one, m == 2 && s == 2)
        if (s == 0 && m != 2) `CHK(sy.mod_dir, 2'h0)
      end
    end
    $display("Test method done");
    apb(1'b1, 1, 8'h00);
    @(posedge pclk);
    tx_bit <= 1'b0;
    repeat (200) @(posedge pclk);
    tx_bit <= 1'b1;
    k = 0;
    w = 0;
    repeat (200) begin
      @(negedge pclk);
      if (sy.mod_active && mclk && sy.mod_weight != 3'h0) begin k++; w += sy.mod_weight; end
    end
    `CHK(k, 4)
    `CHK(w, 8)
    $display("Test edge shaping done");
    `CHK({manch(1'b0), manch(1'b1)}, 4'h9)
    send({12'h000, manch(1'b1), manch(1'b0), manch(1'b0), manch(1'b1)}, 8);
    code = enc_str(15'h0000);
    `CHK(code, 20'hb4b4b)
    code = enc_str(15'h7eb0);
    `CHK(code, 20'hd236b)
    send(code, 20);
    $display("Test line coding done");
    finish_test();
  end
endmodule
